/* File: inc/dadc_consts.vh */
// Constants for the dual converter mode and output control block
`ifndef DADC_CONSTS_VH
`define DADC_CONSTS_VH
// Register offsets (4-bit address)
`define DADC_ADDR_W         4
`define DADC_OFF_STATUS     4'h0
`define DADC_OFF_DES_EN     4'hd
`define DADC_DES_RESET      16'h0000
// dual_edge_enable fields
`define DADC_DES_BIT_EN     15
`define DADC_DES_BIT_APC    14
`define DADC_DES_BIT_SRC    0
// Synchronised pin vector positions
`define DADC_PIN_N          8
`define DADC_PIN_PDALL      0
`define DADC_PIN_PDQ        1
`define DADC_PIN_CAL        2
`define DADC_PIN_CDLY       3
`define DADC_PIN_FLOAT      4
`define DADC_PIN_EXT        5
`define DADC_PIN_EDGE       6
`define DADC_PIN_DDR        7
// Calibration request filter, in input clock cycles
`define DADC_CAL_FILT       7'd80
// Calibration timing defaults, in input clock cycles
`define DADC_DLY_SHORT      24'd4096
`define DADC_DLY_LONG       24'd65536
`define DADC_CAL_LEN        24'd8192
// Offset binary conversion mask
`define DADC_OB_FLIP        8'h80
// Status register layout
`define DADC_ST_W           16
`endif

/* File: rtl/dadc_ctrl.v */
// Dual 8-bit converter mode, power-down, calibration and output demux control
`timescale 1ns/1ps
`include "dadc_consts.vh"
`default_nettype none

module dadc_ctrl
#(
	parameter [23:0] DLY_SHORT = `DADC_DLY_SHORT,
	parameter [23:0] DLY_LONG  = `DADC_DLY_LONG,
	parameter [23:0] CAL_LEN   = `DADC_CAL_LEN
)
(
	// Clock and reset
	input  wire                    sys_clk,
	input  wire                    rstn,
	// Register port
	input  wire [`DADC_ADDR_W-1:0] reg_addr,
	input  wire [15:0]             reg_wdata,
	input  wire                    reg_wr,
	input  wire                    reg_rd,
	output reg  [15:0]             reg_rdata,
	// Control pins
	input  wire                    power_down_all,
	input  wire                    power_down_second_channel,
	input  wire                    cal_request,
	input  wire                    cal_delay_select,
	input  wire                    mode_pin_float,
	input  wire                    extended_ctrl_mode,
	input  wire                    output_edge_select,
	input  wire                    ddr_select,
	// Converter core samples, two's complement
	input  wire [7:0]              conv_i_rise,
	input  wire [7:0]              conv_i_fall,
	input  wire [7:0]              conv_q_rise,
	input  wire [7:0]              conv_q_fall,
	// Output buses
	output reg  [7:0]              bus_i_even,
	output reg  [7:0]              bus_i_odd,
	output reg  [7:0]              bus_q_even,
	output reg  [7:0]              bus_q_odd,
	output reg                     bus_i_oe,
	output reg                     bus_q_oe,
	output reg                     output_data_clock,
	// Status
	output reg                     cal_in_progress
);

	localparam [1:0] ST_DELAY = 2'h0;
	localparam [1:0] ST_RUN   = 2'h1;
	localparam [1:0] ST_CAL   = 2'h2;
	localparam [1:0] ST_DOWN  = 2'h3;

	localparam [1:0] CF_LOW  = 2'h0;
	localparam [1:0] CF_HIGH = 2'h1;
	localparam [1:0] CF_WAIT = 2'h2;

	reg  [`DADC_PIN_N-1:0] pin_meta_reg;
	reg  [`DADC_PIN_N-1:0] pin_sync_reg;
	wire [`DADC_PIN_N-1:0] pin_raw;

	reg  [15:0] des_reg;
	reg  [1:0]  state_reg;
	reg  [1:0]  state_next;
	reg  [23:0] cnt_reg;
	reg  [1:0]  cf_stage_reg;
	reg  [6:0]  cf_cnt_reg;
	reg         cal_fire;
	reg         cal_skip_reg;
	reg         pin_armed_reg;
	reg         ph_reg;
	reg  [7:0]  hold0_reg;
	reg  [7:0]  hold1_reg;
	reg  [15:0] rdata_next;

	wire pd_all   = pin_sync_reg[`DADC_PIN_PDALL];
	wire pd_q     = pin_sync_reg[`DADC_PIN_PDQ];
	wire cal_s    = pin_sync_reg[`DADC_PIN_CAL];
	wire cdly_s   = pin_sync_reg[`DADC_PIN_CDLY];
	wire float_s  = pin_sync_reg[`DADC_PIN_FLOAT];
	wire ext_s    = pin_sync_reg[`DADC_PIN_EXT];
	wire edge_s   = pin_sync_reg[`DADC_PIN_EDGE];
	wire ddr_s    = pin_sync_reg[`DADC_PIN_DDR];

	assign pin_raw = {ddr_select, output_edge_select, extended_ctrl_mode, mode_pin_float,
		cal_delay_select, cal_request, power_down_second_channel, power_down_all};

	// Two-stage synchroniser; full power-down reads high until the pin is seen
	genvar g;
	generate
		for (g = 0; g < `DADC_PIN_N; g = g + 1)
		begin : g_sync
			always @(posedge sys_clk or negedge rstn)
			begin
				if (!rstn)
				begin
					pin_meta_reg[g] <= (g == `DADC_PIN_PDALL);
					pin_sync_reg[g] <= (g == `DADC_PIN_PDALL);
				end
				else
				begin
					pin_meta_reg[g] <= pin_raw[g];
					pin_sync_reg[g] <= pin_meta_reg[g];
				end
			end
		end
	endgenerate

	// Dual-edge selection: register under serial control, floating pin otherwise
	wire des_pin   = float_s && pin_armed_reg;
	wire des_on    = ext_s ? des_reg[`DADC_DES_BIT_EN] : des_pin;
	wire des_src_q = ext_s & des_reg[`DADC_DES_BIT_SRC];
	wire short_dly = ext_s | des_pin | ~cdly_s;
	wire [23:0] dly_target = short_dly ? DLY_SHORT : DLY_LONG;

	// Converter inputs; in dual-edge mode the unused pair is ignored
	wire [7:0] src_rise = des_src_q ? conv_q_rise : conv_i_rise;
	wire [7:0] src_fall = des_src_q ? conv_q_fall : conv_i_fall;
	wire [7:0] conv0 = (des_on ? src_rise : conv_i_rise) ^ `DADC_OB_FLIP;
	wire [7:0] conv1 = (des_on ? src_fall : conv_q_rise) ^ `DADC_OB_FLIP;

	// Power and calibration sequencing
	always @*
	begin
		state_next = state_reg;
		case (state_reg)
			ST_DELAY:
				if (!pd_all && cnt_reg >= dly_target)
					state_next = cal_skip_reg ? ST_RUN : ST_CAL;
			ST_RUN:
				if (pd_all)
					state_next = ST_DOWN;
				else if (cal_fire)
					state_next = ST_CAL;
			ST_CAL:
				if (cnt_reg >= CAL_LEN)
					state_next = pd_all ? ST_DOWN : ST_RUN;
			ST_DOWN:
				if (!pd_all)
					state_next = ST_RUN;
			default:
				state_next = ST_DELAY;
		endcase
	end

	// Reset lands in the power-up delay, analog held down until clocks arrive
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg       <= ST_DELAY;
			cnt_reg         <= 24'h000000;
			cal_skip_reg    <= 1'b0;
			pin_armed_reg   <= 1'b0;
			cal_in_progress <= 1'b0;
		end
		else
		begin
			state_reg       <= state_next;
			cal_in_progress <= (state_next == ST_CAL);
			if (state_next != state_reg)
				cnt_reg <= 24'h000000;
			else if (!(state_reg == ST_DELAY && pd_all))
				cnt_reg <= cnt_reg + 24'h000001;
			if (state_reg == ST_DELAY)
				cal_skip_reg <= cal_s;
			if (!float_s && !cdly_s)
				pin_armed_reg <= 1'b1;
		end
	end

	// Calibration request filter: low 80, high 80, then start after 80 more
	always @*
	begin
		cal_fire = (cf_stage_reg == CF_WAIT) && (cf_cnt_reg >= `DADC_CAL_FILT - 7'd1);
	end

	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cf_stage_reg <= CF_LOW;
			cf_cnt_reg   <= 7'h00;
		end
		else if (state_reg == ST_DOWN || state_reg == ST_CAL || state_reg == ST_DELAY)
		begin
			cf_stage_reg <= CF_LOW;
			cf_cnt_reg   <= 7'h00;
		end
		else
		begin
			case (cf_stage_reg)
				CF_LOW:
					if (cal_s)
					begin
						if (cf_cnt_reg >= `DADC_CAL_FILT)
							cf_stage_reg <= CF_HIGH;
						cf_cnt_reg <= 7'h00;
					end
					else if (cf_cnt_reg < `DADC_CAL_FILT)
						cf_cnt_reg <= cf_cnt_reg + 7'd1;
				CF_HIGH:
					if (!cal_s)
					begin
						cf_stage_reg <= CF_LOW;
						cf_cnt_reg   <= 7'h00;
					end
					else if (cf_cnt_reg >= `DADC_CAL_FILT - 7'd1)
					begin
						cf_stage_reg <= CF_WAIT;
						cf_cnt_reg   <= 7'h00;
					end
					else
						cf_cnt_reg <= cf_cnt_reg + 7'd1;
				CF_WAIT:
					if (cal_fire)
					begin
						cf_stage_reg <= CF_LOW;
						cf_cnt_reg   <= 7'h00;
					end
					else
						cf_cnt_reg <= cf_cnt_reg + 7'd1;
				default:
				begin
					cf_stage_reg <= CF_LOW;
					cf_cnt_reg   <= 7'h00;
				end
			endcase
		end
	end

	wire outs_on = (state_next != ST_DOWN) && !(state_next == ST_DELAY && pd_all);
	// Demux: even samples held, pair released on odd cycle
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ph_reg            <= 1'b0;
			hold0_reg         <= 8'h00;
			hold1_reg         <= 8'h00;
			bus_i_even        <= 8'h00;
			bus_i_odd         <= 8'h00;
			bus_q_even        <= 8'h00;
			bus_q_odd         <= 8'h00;
			bus_i_oe          <= 1'b0;
			bus_q_oe          <= 1'b0;
			output_data_clock <= 1'b0;
		end
		else
		begin
			bus_i_oe <= outs_on;
			bus_q_oe <= outs_on && !pd_q;
			if (state_reg != ST_DOWN)
			begin
				ph_reg <= ~ph_reg;
				if (!ph_reg)
				begin
					hold0_reg <= conv0;
					hold1_reg <= conv1;
				end
				else
				begin
					bus_i_even <= hold0_reg;
					bus_q_even <= hold1_reg;
					bus_i_odd  <= conv0;
					bus_q_odd  <= conv1;
				end
				if (ddr_s)
				begin
					if (ph_reg)
						output_data_clock <= ~output_data_clock;
				end
				else
					output_data_clock <= ph_reg ? edge_s : ~edge_s;
			end
		end
	end

	// Register port
	always @*
	begin
		rdata_next = 16'h0000;
		case (reg_addr)
			`DADC_OFF_DES_EN:
				rdata_next = des_reg;
			`DADC_OFF_STATUS:
				rdata_next = {8'h00, ext_s, des_src_q, des_on, pd_q, state_reg, short_dly,
					cal_in_progress};
			default:
				rdata_next = 16'h0000;
		endcase
	end

	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			des_reg   <= `DADC_DES_RESET;
			reg_rdata <= 16'h0000;
		end
		else
		begin
			if (reg_wr && reg_addr == `DADC_OFF_DES_EN)
				des_reg <= reg_wdata;
			reg_rdata <= reg_rd ? rdata_next : 16'h0000;
		end
	end

endmodule

`default_nettype wire

/* File: tb/dadc_monitor.sv */
// Port checker for the converter control block
`timescale 1ns/1ps
`default_nettype none
module dadc_monitor #(parameter [23:0] CAL_LEN = 24'd20)
(
	// Clock and reset
	input wire logic       sys_clk,
	input wire logic       rstn,
	// Pins
	input wire logic       power_down_all,
	input wire logic       power_down_second_channel,
	input wire logic       output_edge_select,
	input wire logic       ddr_select,
	// Outputs
	input wire logic [7:0] bus_i_even,
	input wire logic       bus_i_oe,
	input wire logic       bus_q_oe,
	input wire logic       output_data_clock,
	input wire logic       cal_in_progress
);
	logic [23:0] hi_cnt;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// Length of the current calibration
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			hi_cnt <= 24'h0;
		else
			hi_cnt <= cal_in_progress ? hi_cnt + 24'h1 : 24'h0;
	end
	AST_PD_OFF: assert property (
		(power_down_all && !cal_in_progress)[*4] |=> !bus_i_oe && !bus_q_oe)
		else $error("outputs driven in power-down");
	AST_Q_OFF: assert property (
		power_down_second_channel[*4] |=> !bus_q_oe) else $error("second bus driven");
	AST_Q_ONLY: assert property (
		(power_down_second_channel && !power_down_all)[*2] ##0 $fell(bus_q_oe) |-> bus_i_oe)
		else $error("first channel stopped");
	AST_HOLD: assert property (
		$changed(bus_i_even) |=> $stable(bus_i_even)) else $error("word held one cycle");
	AST_SDR: assert property (
		(bus_i_oe && !ddr_select && $stable(output_edge_select))[*6] |-> $changed(output_data_clock))
		else $error("data clock stalled");
	AST_EDGE: assert property (
		(!ddr_select && $stable(output_edge_select) && bus_i_oe)[*6] ##0 $changed(bus_i_even)
		|-> output_data_clock == output_edge_select) else $error("data on wrong edge");
	AST_DDR: assert property (
		(ddr_select && bus_i_oe)[*6] ##0 $rose(output_data_clock)
		|-> ##4 ($rose(output_data_clock) || !ddr_select)) else $error("ddr period wrong");
	AST_CAL_LEN: assert property (
		$fell(cal_in_progress) |-> hi_cnt == CAL_LEN + 24'h1) else $error("cal length wrong");
endmodule
bind dadc_ctrl dadc_monitor #(.CAL_LEN(CAL_LEN)) dadc_monitor_inst (.sys_clk, .rstn,
	.power_down_all, .power_down_second_channel, .output_edge_select, .ddr_select,
	.bus_i_even, .bus_i_oe, .bus_q_oe, .output_data_clock, .cal_in_progress);
`default_nettype wire

/* File: tb/dadc_capture.sv */
// Capture logic at the far end of the output buses
`timescale 1ns/1ps
`default_nettype none
module dadc_capture #(parameter int FLUSH = 4)
(
	// Clock
	input wire logic       sys_clk,
	// First converter buses only
	input wire logic [7:0] bus_i_even,
	input wire logic [7:0] bus_i_odd,
	input wire logic       bus_i_oe,
	input wire logic       output_data_clock,
	input wire logic       output_edge_select,
	// Captured pair
	output var logic [7:0] cap_even,
	output var logic [7:0] cap_odd,
	output var int         cap_n
);
	initial cap_n = 0;
	// Sample mid-word, on the clock phase opposite to the data change
	always @(posedge sys_clk)
	begin
		if (!bus_i_oe)
			cap_n <= 0;
		else if (output_data_clock != output_edge_select)
			cap_n <= cap_n + 1;
		if (bus_i_oe && cap_n >= FLUSH && output_data_clock != output_edge_select)
		begin
			cap_even <= bus_i_even;
			cap_odd <= bus_i_odd;
		end
	end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking testbench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic       sys_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, ramp = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata;
	logic       power_down_all = 1'b1, power_down_second_channel = 1'b0, cal_request = 1'b0;
	logic       cal_delay_select = 1'b0, mode_pin_float = 1'b0, extended_ctrl_mode = 1'b0;
	logic       output_edge_select = 1'b0, ddr_select = 1'b0;
	logic [7:0] conv_i_rise = 8'h00, conv_i_fall = 8'h00, conv_q_rise = 8'h00;
	logic [7:0] conv_q_fall = 8'h00, cnt = 8'h00, code_v = 8'h00, cap_even, cap_odd;
	logic [7:0] bus_i_even, bus_i_odd, bus_q_even, bus_q_odd;
	logic       bus_i_oe, bus_q_oe, output_data_clock, cal_in_progress;
	int         n_errors = 0, num_checks = 0, cyc = 0, cap_n;
	dadc_ctrl #(.DLY_SHORT(24'd16), .DLY_LONG(24'd32), .CAL_LEN(24'd20)) dadc_ctrl_inst (
		.sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.power_down_all, .power_down_second_channel, .cal_request, .cal_delay_select,
		.mode_pin_float, .extended_ctrl_mode, .output_edge_select, .ddr_select,
		.conv_i_rise, .conv_i_fall, .conv_q_rise, .conv_q_fall, .bus_i_even, .bus_i_odd,
		.bus_q_even, .bus_q_odd, .bus_i_oe, .bus_q_oe, .output_data_clock, .cal_in_progress);
	dadc_capture dadc_capture_inst (.sys_clk, .bus_i_even, .bus_i_odd, .bus_i_oe,
		.output_data_clock, .output_edge_select, .cap_even, .cap_odd, .cap_n);
	initial forever #2.5 sys_clk = ~sys_clk;
	// Ramp source: rising samples even, falling odd; second input ramps downwards
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		cnt <= cnt + 8'h02;
		if (ramp)
			{conv_i_rise, conv_q_rise, conv_i_fall, conv_q_fall} <=
				{cnt, 8'h00 - cnt, cnt + 8'h01, 8'hff - cnt};
		else
			{conv_i_rise, conv_q_rise, conv_i_fall, conv_q_fall} <= {4{code_v}};
		if (cyc == 5000)
		begin
			n_errors++;
			conclude();
		end
	end
	task automatic conclude;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic wait_cal(input logic v, input int n);
		for (int i = 0; i < n && cal_in_progress !== v; i++)
			@(posedge sys_clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		tick(1);
		reg_wr <= 1'b0;
		tick(1);
	endtask
	task automatic rchk(input logic [3:0] a, input logic [15:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		tick(1);
		reg_rd <= 1'b0;
		#1 check(reg_rdata, e);
		tick(1);
	endtask
	task automatic t_powerup;
		tick(60);
		check(cal_in_progress, 1'b0);
		power_down_all <= 1'b0;
		wait_cal(1'b1, 100);
		check(cal_in_progress, 1'b1);
		wait_cal(1'b0, 100);
		$display("test powerup done");
	endtask
	task automatic t_regs;
		rchk(4'hd, 16'h0000);
		wr(4'hd, 16'hc001);
		rchk(4'hd, 16'hc001);
		wr(4'h5, 16'hffff);
		rchk(4'h5, 16'h0000);
		wr(4'hd, 16'h0000);
		$display("test regs done");
	endtask
	task automatic t_codes;
		logic [7:0] v [4] = '{8'h7f, 8'h80, 8'h00, 8'hff};
		foreach (v[k])
		begin
			code_v <= v[k];
			tick(8);
			check(bus_i_even, v[k] ^ 8'h80);
			check(bus_q_odd, v[k] ^ 8'h80);
		end
		$display("test codes done");
	endtask
	task automatic t_demux;
		ramp <= 1'b1;
		for (int e = 0; e < 2; e++)
		begin
			output_edge_select <= e[0];
			tick(30);
			check(cap_n > 4, 1'b1);
			check(8'((cap_odd ^ 8'h80) - (cap_even ^ 8'h80)), 8'h02);
		end
		$display("test demux done");
	endtask
	task automatic t_ddr;
		int n;
		logic p;
		ddr_select <= 1'b1;
		tick(10);
		n = 0;
		p = output_data_clock;
		for (int i = 0; i < 40; i++)
		begin
			tick(1);
			n += int'(output_data_clock !== p);
			p = output_data_clock;
		end
		check(n, 20);
		ddr_select <= 1'b0;
		tick(10);
		$display("test ddr done");
	endtask
	task automatic t_des;
		for (int m = 0; m < 3; m++)
		begin
			extended_ctrl_mode <= (m < 2);
			mode_pin_float <= (m == 2);
			if (m < 2)
				wr(4'hd, {1'b1, 14'h0, m[0]});
			tick(20);
			check(8'((bus_q_even ^ 8'h80) - (bus_i_even ^ 8'h80)), (m == 1) ? 8'hff : 8'h01);
			check(8'((bus_i_odd ^ 8'h80) - (bus_i_even ^ 8'h80)), (m == 1) ? 8'hfe : 8'h02);
			check(8'((bus_q_odd ^ 8'h80) - (bus_i_even ^ 8'h80)), (m == 1) ? 8'hfd : 8'h03);
			rchk(4'h0, {8'h00, m < 2, m == 1, 6'h26});
		end
		mode_pin_float <= 1'b0;
		tick(10);
		$display("test des done");
	endtask
	task automatic t_pdq;
		power_down_second_channel <= 1'b1;
		tick(6);
		check({bus_i_oe, bus_q_oe}, 2'b10);
		power_down_second_channel <= 1'b0;
		tick(6);
		check(bus_q_oe, 1'b1);
		$display("test pdq done");
	endtask
	task automatic t_cal;
		cal_request <= 1'b1;
		tick(160);
		check(cal_in_progress, 1'b0);
		wait_cal(1'b1, 10);
		check(cal_in_progress, 1'b1);
		power_down_all <= 1'b1;
		tick(6);
		check(cal_in_progress, 1'b1);
		wait_cal(1'b0, 40);
		tick(6);
		check({bus_i_oe, bus_q_oe}, 2'b00);
		cal_request <= 1'b0;
		tick(100);
		cal_request <= 1'b1;
		tick(250);
		check(cal_in_progress, 1'b0);
		power_down_all <= 1'b0;
		tick(250);
		check(cal_in_progress, 1'b0);
		cal_request <= 1'b0;
		$display("test cal done");
	endtask
	initial
	begin
		tick(6);
		rstn <= 1'b1;
		t_powerup();
		t_regs();
		t_codes();
		t_demux();
		t_ddr();
		t_des();
		t_pdq();
		t_cal();
		conclude();
	end
endmodule
`default_nettype wire
